// File: pli_fifo.sv
// Purpose: flip-flop fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes:   depth must be a power of two
`timescale 1ns/100ps
module pli_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad_size
        $error("pli_fifo: depth must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;

    assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge mclk)
    begin
        if (in_valid && in_ready)
            mem_q[wr_q[AW-1:0]] <= in_data;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            wr_q <= '0;
        else if (in_valid && in_ready)
            wr_q <= wr_q + 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            rd_q <= '0;
        else if (out_valid && out_ready)
            rd_q <= rd_q + 1'b1;
    end
endmodule // pli_fifo

// File: pli_link.sv
// Purpose: link end of the physical-layer interface: request, grant, lanes, cycle sync
// Assumes: phy clock is sampled by mclk (50 MHz) and its rising edges found
// Notes:   transmit data is buffered; at every speed the phy clock is near mclk, so
//          lane sampling is best effort and the sampled lanes lag the pins
// Function
// - control lanes stay released until the phy grants after our request
// - data lanes driven only while transmitting, else released
// - only lanes valid for the speed are used; upper lanes ignored
// - power status asserted while the link is powered, else deasserted
// - request line serially asks the phy for service such as bus access
// - the link drives an 8 kHz cycle sync output
`timescale 1ns/100ps
`include "pli_regs.svh"
module pli_link
    import pli_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic            mclk,
    input  wire logic            rst,
    input  wire logic            phy_system_clock,
    input  wire logic [1:0]      phy_ctl_in,
    output logic      [1:0]      phy_ctl_out,
    output logic                 phy_ctl_oe_n,
    input  wire logic [7:0]      phy_data_in,
    output logic      [7:0]      phy_data_out,
    output logic                 phy_data_oe_n,
    output logic                 link_service_request,
    input  wire logic            wake_pulse_in,
    output logic                 link_power_status,
    input  wire logic            cycle_sync_input,
    output logic                 cycle_sync_output,
    input  wire logic            power_on,
    input  wire logic            ext_cycle_enable,
    output logic                 wake_request,
    input  wire pli_speed_e      tx_speed,
    input  wire logic            tx_valid,
    output logic                 tx_ready,
    input  wire pli_word_s       tx_word,
    output logic                 rx_valid,
    output pli_word_s            rx_word,
    output pli_speed_e           rx_speed,
    output logic                 busy
);
    import pli_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_WAIT, ST_TX, ST_HOLD, ST_RX} pli_state_e;

    // bits carried per phy clock for a speed
    function automatic logic [3:0] pli_lanes(input pli_speed_e s);
        unique case (s)
            PLI_S100: pli_lanes = 4'h2;
            PLI_S200: pli_lanes = 4'h4;
            default:  pli_lanes = 4'h8;
        endcase
    endfunction

    // keep valid lanes only
    function automatic logic [7:0] pli_mask(input pli_speed_e s, input logic [7:0] d);
        unique case (s)
            PLI_S100: pli_mask = {6'h00, d[1:0]};
            PLI_S200: pli_mask = {4'h0, d[3:0]};
            default:  pli_mask = d;
        endcase
    endfunction

    // lane inputs pass two flops before use
    logic        sclk_s;
    logic        cyc_in_s;
    logic        wake_s;
    pli_lanes_s  lanes_s;

    pli_sync #(.WIDTH(13)) u_sync (
        .mclk     (mclk),
        .rst      (rst),
        .async_in ({phy_system_clock, cycle_sync_input, wake_pulse_in, phy_ctl_in, phy_data_in}),
        .sync_out ({sclk_s, cyc_in_s, wake_s, lanes_s})
    );

    logic sclk_prev_q;
    logic cyc_prev_q;
    logic wake_prev_q;
    logic sclk_rise;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            sclk_prev_q <= 1'b0;
            cyc_prev_q  <= 1'b0;
            wake_prev_q <= 1'b0;
        end
        else
        begin
            sclk_prev_q <= sclk_s;
            cyc_prev_q  <= cyc_in_s;
            wake_prev_q <= wake_s;
        end
    end

    assign sclk_rise = sclk_s && !sclk_prev_q;

    // transmit buffer
    logic       fifo_valid;
    logic       fifo_ready;
    pli_word_s  fifo_word;

    pli_fifo #(.WIDTH($bits(pli_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_word),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_word)
    );

    pli_state_e state_q;
    logic [3:0] req_cnt_q;
    logic [8:0] req_sr_q;
    logic [7:0] shift_q;
    logic [3:0] bit_q;
    logic       last_q;
    logic [7:0] rx_sh_q;
    logic [3:0] rx_bit_q;
    pli_speed_e cur_spd_q;
    logic       word_end;
    logic       first_pop;

    assign word_end   = (bit_q + pli_lanes(cur_spd_q)) >= 4'h8;
    assign fifo_ready = first_pop || (sclk_rise && state_q == ST_TX && word_end && !last_q
                        && fifo_valid);

    // request fires only with a word waiting in the fifo and power status up
    always_ff @(posedge mclk)
    begin
        if (rst)
            state_q <= ST_IDLE;
        else if (sclk_rise)
        begin
            unique case (state_q)
                ST_IDLE:
                    if (lanes_s.ctl == `PLI_CTL_RECEIVE)
                        state_q <= ST_RX;
                    else if (fifo_valid && link_power_status)
                        state_q <= ST_REQ;
                ST_REQ:
                    if (req_cnt_q == `PLI_REQ_BITS)
                        state_q <= ST_WAIT;
                ST_WAIT:
                    if (lanes_s.ctl == `PLI_CTL_GRANT)
                        state_q <= ST_TX;
                    else if (lanes_s.ctl == `PLI_CTL_RECEIVE)
                        state_q <= ST_RX;
                ST_TX:
                    if (word_end && last_q)
                        state_q <= ST_HOLD;
                    else if (word_end && !fifo_valid)
                        state_q <= ST_HOLD;
                // one phy clock of idle code on the lanes before they are released
                ST_HOLD:
                    if (phy_ctl_out == `PLI_CTL_IDLE)
                        state_q <= ST_IDLE;
                ST_RX:
                    if (lanes_s.ctl == `PLI_CTL_IDLE)
                        state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // serial request: start, immediate type, speed, stop
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            req_cnt_q <= 4'h0;
            req_sr_q  <= '0;
        end
        else if (sclk_rise)
        begin
            if (state_q == ST_IDLE)
            begin
                req_cnt_q <= 4'h0;
                req_sr_q  <= {1'b1, `PLI_REQ_TYPE_IMM, 2'h0, tx_speed, 1'b0};
            end
            else if (state_q == ST_REQ)
            begin
                req_cnt_q <= req_cnt_q + 4'h1;
                req_sr_q  <= {req_sr_q[7:0], 1'b0};
            end
        end
    end

    assign link_service_request = (state_q == ST_REQ) && req_sr_q[8];

    // transmit shifter, least significant lanes carry data
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            shift_q   <= 8'h00;
            bit_q     <= 4'h0;
            last_q    <= 1'b0;
            cur_spd_q <= PLI_S100;
        end
        else if (sclk_rise)
        begin
            if (state_q == ST_WAIT)
            begin
                shift_q   <= fifo_word.data;
                last_q    <= fifo_word.last;
                bit_q     <= 4'h0;
                cur_spd_q <= tx_speed;
            end
            else if (state_q == ST_TX)
            begin
                if (word_end)
                begin
                    shift_q <= fifo_word.data;
                    last_q  <= fifo_word.last;
                    bit_q   <= 4'h0;
                end
                else
                begin
                    shift_q <= shift_q >> pli_lanes(cur_spd_q);
                    bit_q   <= bit_q + pli_lanes(cur_spd_q);
                end
            end
        end
    end

    // first word leaves the fifo on the grant edge, when the shifter loads it
    assign first_pop = sclk_rise && state_q == ST_WAIT && lanes_s.ctl == `PLI_CTL_GRANT
                       && fifo_valid;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            phy_ctl_out   <= 2'h0;
            phy_ctl_oe_n  <= 1'b1;
            phy_data_out  <= 8'h00;
            phy_data_oe_n <= 1'b1;
        end
        else if (sclk_rise)
        begin
            phy_ctl_oe_n  <= !(state_q == ST_TX
                               || (state_q == ST_HOLD && phy_ctl_out != `PLI_CTL_IDLE));
            phy_data_oe_n <= !(state_q == ST_TX);
            phy_ctl_out   <= (state_q == ST_TX) ? `PLI_CTL_TRANSMIT : `PLI_CTL_IDLE;
            phy_data_out  <= pli_mask(cur_spd_q, shift_q);
        end
    end

    // receive: gather valid lanes into bytes
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rx_sh_q  <= 8'h00;
            rx_bit_q <= 4'h0;
            rx_valid <= 1'b0;
            rx_word  <= '0;
            rx_speed <= PLI_S100;
        end
        else
        begin
            rx_valid <= 1'b0;
            if (sclk_rise && state_q == ST_RX)
            begin
                if (lanes_s.ctl == `PLI_CTL_RECEIVE)
                begin
                    rx_sh_q  <= rx_sh_q | (pli_mask(rx_speed, lanes_s.data) << rx_bit_q);
                    rx_bit_q <= rx_bit_q + pli_lanes(rx_speed);
                    if ((rx_bit_q + pli_lanes(rx_speed)) >= 4'h8)
                    begin
                        rx_valid      <= 1'b1;
                        rx_word.data  <= rx_sh_q | (pli_mask(rx_speed, lanes_s.data) << rx_bit_q);
                        rx_word.last  <= 1'b0;
                        rx_sh_q       <= 8'h00;
                        rx_bit_q      <= 4'h0;
                    end
                end
                else
                begin
                    rx_valid     <= rx_bit_q != 4'h0;
                    rx_word.data <= rx_sh_q;
                    rx_word.last <= 1'b1;
                    rx_sh_q      <= 8'h00;
                    rx_bit_q     <= 4'h0;
                end
            end
            // speed code rides the data lanes on the cycle that opens a receive
            else if (sclk_rise && state_q == ST_IDLE && lanes_s.ctl == `PLI_CTL_RECEIVE)
                rx_speed <= pli_speed_e'(lanes_s.data[1:0]);
        end
    end

    // wake pulse request stays until power is up; set beats clear
    always_ff @(posedge mclk)
    begin
        if (rst)
            wake_request <= 1'b0;
        else if (wake_s && !wake_prev_q)
            wake_request <= 1'b1;
        else if (link_power_status)
            wake_request <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            link_power_status <= 1'b0;
        else
            link_power_status <= power_on;
    end

    // cycle timer counts phy clocks, or follows the external 8 kHz edge
    logic [12:0] cyc_cnt_q;
    logic        cyc_wrap;
    assign cyc_wrap = ext_cycle_enable ? (cyc_in_s && !cyc_prev_q)
                                       : (sclk_rise && cyc_cnt_q == `PLI_SCLK_PER_CYC - 13'h1);

    always_ff @(posedge mclk)
    begin
        if (rst)
            cyc_cnt_q <= 13'h0000;
        else if (cyc_wrap)
            cyc_cnt_q <= 13'h0000;
        else if (sclk_rise && cyc_cnt_q != `PLI_SCLK_PER_CYC - 13'h1)
            cyc_cnt_q <= cyc_cnt_q + 13'h1;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            cycle_sync_output <= 1'b0;
        else
            cycle_sync_output <= cyc_cnt_q < `PLI_PULSE_SCLK;
    end

    assign busy = (state_q != ST_IDLE) || first_pop;
endmodule // pli_link

// File: pli_link_sva.sv
// Purpose: port checks for pli_link
// Assumes: one mclk domain, rst synchronous active high
// Notes:   grant window sized for a 160 ns phy clock
`timescale 1ns/100ps
module pli_link_sva
    import pli_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic [1:0] phy_ctl_in,
    input wire logic       phy_ctl_oe_n,
    input wire logic [7:0] phy_data_out,
    input wire logic       phy_data_oe_n,
    input wire logic       link_service_request,
    input wire logic       wake_pulse_in,
    input wire logic       link_power_status,
    input wire logic       cycle_sync_output,
    input wire logic       power_on,
    input wire logic       wake_request,
    input wire pli_speed_e tx_speed,
    input wire logic       rx_valid,
    input wire logic       busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic [5:0] since_gnt_q;

    // saturates so a stale grant never excuses a late drive
    always_ff @(posedge mclk)
    begin
        if (rst)
            since_gnt_q <= 6'h3f;
        else if (phy_ctl_in == 2'h3)
            since_gnt_q <= 6'h00;
        else if (since_gnt_q != 6'h3f)
            since_gnt_q <= since_gnt_q + 6'h01;
    end

    AST_CTL_AFTER_GRANT: assert property ($fell(phy_ctl_oe_n) |-> since_gnt_q < 6'h18)
        else $error("control lanes driven without a recent grant");
    AST_CTL_ONLY_BUSY: assert property (!phy_ctl_oe_n |-> busy)
        else $error("control lanes driven while idle");
    AST_DATA_WITH_CTL: assert property (!phy_data_oe_n |-> !phy_ctl_oe_n)
        else $error("data lanes driven outside a transmit");
    AST_LANES_100: assert property (
        !phy_data_oe_n && tx_speed == PLI_S100 |-> phy_data_out[7:2] == 6'h00)
        else $error("upper lanes active at lowest speed");
    AST_LANES_200: assert property (
        !phy_data_oe_n && tx_speed == PLI_S200 |-> phy_data_out[7:4] == 4'h0)
        else $error("upper lanes active at middle speed");
    AST_POWER_STATUS: assert property (
        !$past(rst) |-> link_power_status == $past(power_on))
        else $error("power status does not follow power");
    AST_REQ_NEEDS_POWER: assert property (!link_power_status |-> !link_service_request)
        else $error("request sent while unpowered");
    AST_WAKE_SET: assert property (
        $rose(wake_pulse_in) && !power_on && !link_power_status |-> ##[1:5] wake_request)
        else $error("wake pulse not taken");
    AST_WAKE_CLEAR: assert property (
        $rose(link_power_status) && !wake_pulse_in |-> ##[1:2] !wake_request)
        else $error("wake request kept after power up");
    AST_CYCLE_WIDTH: assert property ($rose(cycle_sync_output) |-> cycle_sync_output[*8])
        else $error("cycle sync pulse too short");

    COV_DRIVE: cover property ($fell(phy_ctl_oe_n));
    COV_RX: cover property (rx_valid);
    COV_CYCLE: cover property ($rose(cycle_sync_output));
endmodule // pli_link_sva

bind pli_link pli_link_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_pli_link_sva (
    .mclk(mclk), .rst(rst), .phy_ctl_in(phy_ctl_in), .phy_ctl_oe_n(phy_ctl_oe_n),
    .phy_data_out(phy_data_out), .phy_data_oe_n(phy_data_oe_n),
    .link_service_request(link_service_request), .wake_pulse_in(wake_pulse_in),
    .link_power_status(link_power_status), .cycle_sync_output(cycle_sync_output),
    .power_on(power_on), .wake_request(wake_request), .tx_speed(tx_speed),
    .rx_valid(rx_valid), .busy(busy));

// File: pli_link_test.sv
// Purpose: self-checking bench for pli_link
// Assumes: 50 MHz mclk, phy model clock 160 ns
// Notes:   the cycle-sync wait dominates run time
`timescale 1ns/100ps
module pli_link_test;
    import pli_pkg::*;
    logic       mclk, rst, sclk, lreq, wake, wreq, lps, pwr, cyo, busy, cyi, ext_en;
    logic       ctl_oe_n, data_oe_n, m_ctl_en, m_data_en, tx_valid, tx_ready, rx_valid;
    logic [1:0] ctl_out, ctl_w, m_ctl;
    logic [7:0] data_out, data_w, m_data;
    pli_speed_e tx_speed, rx_speed;
    pli_word_s  tx_word, rx_word;
    pli_word_s  rxq[$];
    int         err_total = 0;
    int         cmp_count = 0;
    int         cyc = 0;

    // pull-downs hold released lanes low
    assign ctl_w = !ctl_oe_n ? ctl_out : (m_ctl_en ? m_ctl : 2'h0);
    assign data_w = !data_oe_n ? data_out : (m_data_en ? m_data : 8'h00);

    pli_link #(.FIFO_DEPTH(16)) u_pli_link (
        .mclk(mclk), .rst(rst), .phy_system_clock(sclk), .phy_ctl_in(ctl_w),
        .phy_ctl_out(ctl_out), .phy_ctl_oe_n(ctl_oe_n), .phy_data_in(data_w),
        .phy_data_out(data_out), .phy_data_oe_n(data_oe_n), .link_service_request(lreq),
        .wake_pulse_in(wake), .link_power_status(lps), .cycle_sync_output(cyo),
        .cycle_sync_input(cyi), .ext_cycle_enable(ext_en),
        .power_on(pwr), .wake_request(wreq), .tx_speed(tx_speed), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_word(tx_word), .rx_valid(rx_valid), .rx_word(rx_word),
        .rx_speed(rx_speed), .busy(busy));

    pli_phy_model u_pli_phy_model (
        .phy_system_clock(sclk), .link_service_request(lreq), .phy_ctl_oe_n(ctl_oe_n),
        .ctl_w(ctl_w), .data_w(data_w), .ctl_drv(m_ctl), .ctl_en(m_ctl_en),
        .data_drv(m_data), .data_en(m_data_en));

    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // valid stays up between words; the caller lowers it
    task automatic push(input logic [7:0] b, input logic last);
        int k;
        k = 0;
        tx_valid = 1'b1;
        tx_word = '{data: b, last: last};
        while (tx_ready !== 1'b1 && k < 100)
        begin
            step(1);
            k++;
        end
        step(1);
    endtask

    task automatic wait_done(input int n, input logic [1:0] spd, input logic [7:0] b0);
        int k;
        k = 0;
        while ((u_pli_phy_model.got.size() < n || ctl_oe_n !== 1'b1) && k < 5000)
        begin
            step(1);
            k++;
        end
        chk("data lanes released", 16'h1, data_oe_n);
        chk("busy after frame", 16'h0, busy);
        chk("request speed", spd, u_pli_phy_model.req_q[2:1]);
        chk("request type", 16'h0, {u_pli_phy_model.req_q[7:3], u_pli_phy_model.req_q[0]});
        for (int i = 0; i < n; i++)
            chk("sent byte", b0 + i[7:0], u_pli_phy_model.got[i]);
    endtask

    task automatic t_fill();
        int n;
        n = 0;
        tx_speed = PLI_S400;
        while (tx_ready === 1'b1 && n < 20)
        begin
            tx_valid = 1'b1;
            tx_word = '{data: 8'h10 + n[7:0], last: n == 15};
            step(1);
            n++;
        end
        tx_valid = 1'b0;
        chk("fifo words", 16'd16, n[15:0]);
        step(200);
        chk("requests unpowered", 16'h0, u_pli_phy_model.req_cnt[15:0]);
        chk("ctl released", 16'h1, ctl_oe_n);
        $display("test fill done");
    endtask

    task automatic t_wake_drain();
        u_pli_phy_model.gnt_wait = 6;
        wake = 1'b1;
        step(4);
        wake = 1'b0;
        step(4);
        chk("wake request", 16'h1, wreq);
        chk("power status off", 16'h0, lps);
        pwr = 1'b1;
        step(3);
        chk("power status on", 16'h1, lps);
        chk("wake cleared", 16'h0, wreq);
        wait_done(16, 2'h2, 8'h10);
        $display("test wake drain done");
    endtask

    task automatic t_speed(input pli_speed_e s);
        u_pli_phy_model.gnt_wait = 1;
        u_pli_phy_model.got.delete();
        tx_speed = s;
        for (int i = 0; i < 3; i++)
            push(8'ha5 + i[7:0], i == 2);
        tx_valid = 1'b0;
        wait_done(3, s, 8'ha5);
        $display("test speed %0d done", s);
    endtask

    task automatic t_receive();
        rxq.delete();
        fork
            u_pli_phy_model.rx_frame(16'hb74e);
            repeat (600)
            begin
                step(1);
                if (rx_valid === 1'b1)
                    rxq.push_back(rx_word);
            end
        join
        chk("rx count", 16'd2, rxq.size());
        chk("rx byte 0", 16'h4e, rxq[0].data);
        chk("rx byte 1", 16'hb7, rxq[1].data);
        chk("rx speed", PLI_S200, rx_speed);
        $display("test receive done");
    endtask

    task automatic wait_lvl(input logic v, output int n);
        n = 0;
        while (cyo !== v && n < 60000)
        begin
            step(1);
            n++;
        end
    endtask

    task automatic t_cycle();
        int n;
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, n);
        // 16 phy clocks of 8 mclk each, give or take an edge
        chk("cycle pulse width ok", 16'h1, n >= 120 && n <= 136);
        $display("test cycle done");
    endtask

    // external cycle input: its rising edge restarts the timer at once
    task automatic t_ext_cycle();
        int n;
        ext_en = 1'b1;
        step(40);
        chk("cycle sync idle", 16'h0, cyo);
        cyi = 1'b1;
        wait_lvl(1'b1, n);
        chk("ext cycle follows input", 16'h1, n <= 8);
        cyi = 1'b0;
        wait_lvl(1'b0, n);
        chk("ext cycle pulse width ok", 16'h1, n >= 120 && n <= 136);
        $display("test ext cycle done");
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            err_total++;
            close_out();
        end
    end

    initial
    begin
        rst = 1'b1;
        pwr = 1'b0;
        wake = 1'b0;
        cyi = 1'b0;
        ext_en = 1'b0;
        tx_valid = 1'b0;
        tx_word = '0;
        tx_speed = PLI_S400;
        step(16);
        rst = 1'b0;
        t_fill();
        t_wake_drain();
        t_speed(PLI_S100);
        t_speed(PLI_S200);
        t_receive();
        t_cycle();
        t_ext_cycle();
        close_out();
    end
endmodule // pli_link_test

// File: pli_phy_model.sv
// Purpose: behavioural phy facing pli_link
// Assumes: free-running 160 ns phy clock; released lanes pulled low
// Notes:   drives on falling edges so the link samples settled levels
`timescale 1ns/100ps
module pli_phy_model (
    output logic       phy_system_clock,
    input  wire logic  link_service_request,
    input  wire logic  phy_ctl_oe_n,
    input  wire logic [1:0] ctl_w,
    input  wire logic [7:0] data_w,
    output logic [1:0] ctl_drv,
    output logic       ctl_en,
    output logic [7:0] data_drv,
    output logic       data_en
);
    logic [7:0] req_q;
    logic [7:0] acc_q;
    logic [7:0] got[$];
    int         nbit = 0;
    int         req_cnt = 0;
    int         gnt_wait = 1;

    initial
    begin
        phy_system_clock = 1'b0;
        forever #80 phy_system_clock = ~phy_system_clock;
    end

    initial
    begin
        ctl_drv = 2'h0;
        ctl_en = 1'b0;
        data_drv = 8'h00;
        data_en = 1'b0;
        forever
        begin
            @(posedge phy_system_clock);
            if (link_service_request === 1'b1)
            begin
                for (int i = 7; i >= 0; i--)
                begin
                    @(posedge phy_system_clock);
                    req_q[i] = link_service_request;
                end
                req_cnt++;
                // gnt_wait models a phy that is slow to arbitrate
                repeat (gnt_wait) @(posedge phy_system_clock);
                @(negedge phy_system_clock);
                ctl_drv = 2'h3;
                ctl_en = 1'b1;
                @(negedge phy_system_clock);
                ctl_en = 1'b0;
            end
        end
    end

    always @(posedge phy_system_clock)
    begin
        if (phy_ctl_oe_n === 1'b0 && ctl_w === 2'h2)
        begin
            case (req_q[2:1])
                2'h0: acc_q = {data_w[1:0], acc_q[7:2]};
                2'h1: acc_q = {data_w[3:0], acc_q[7:4]};
                default: acc_q = data_w;
            endcase
            nbit = nbit + (2 << req_q[2:1]);
            if (nbit >= 8)
            begin
                got.push_back(acc_q);
                nbit = 0;
            end
        end
    end

    // middle-speed receive of two bytes; upper lanes carry junk on purpose
    task automatic rx_frame(input logic [15:0] b);
        // the opening receive cycle carries the speed code on the low lanes
        @(negedge phy_system_clock);
        ctl_drv = 2'h2;
        data_drv = 8'hf1;
        ctl_en = 1'b1;
        data_en = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            @(negedge phy_system_clock);
            ctl_drv = 2'h2;
            data_drv = {~b[4*i +: 4], b[4*i +: 4]};
        end
        @(negedge phy_system_clock);
        ctl_drv = 2'h0;
        @(negedge phy_system_clock);
        ctl_en = 1'b0;
        data_en = 1'b0;
    endtask
endmodule // pli_phy_model

// File: pli_pkg.sv
// Purpose: shared types for the physical-layer link interface
// Assumes: included constants header
// Notes:   structs carry lane groups together
package pli_pkg;
    typedef enum logic [1:0] {PLI_S100, PLI_S200, PLI_S400, PLI_SRSV} pli_speed_e;

    typedef struct packed {
        logic [1:0] ctl;
        logic [7:0] data;
    } pli_lanes_s;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } pli_word_s;
endpackage

// File: pli_regs.svh
// Purpose: constants for the link side of the physical-layer interface
// Assumes: mclk at 50 MHz; phy clock sampled as an ordinary input
// Notes:   control lane codes follow the standard link/phy interface
`ifndef PLI_REGS_SVH
`define PLI_REGS_SVH

// control lane codes while the phy drives
`define PLI_CTL_IDLE      2'h0
`define PLI_CTL_STATUS    2'h1
`define PLI_CTL_RECEIVE   2'h2
`define PLI_CTL_GRANT     2'h3
// control lane codes while the link drives
`define PLI_CTL_HOLD      2'h1
`define PLI_CTL_TRANSMIT  2'h2
// request serial format: start bit, 3 type bits, 4 speed bits, stop bit
`define PLI_REQ_BITS      4'h9
`define PLI_REQ_TYPE_IMM  3'h0
// speed codes
`define PLI_SPD_100       2'h0
`define PLI_SPD_200       2'h1
`define PLI_SPD_400       2'h2
// cycle timer: 8 kHz from a 49.152 MHz phy clock
`define PLI_SCLK_PER_CYC  13'h1800
`define PLI_PULSE_SCLK    13'h0010
`endif

// File: pli_sync.sv
// Purpose: two-flop synchroniser for a bus of pin levels
// Assumes: inputs asynchronous to mclk
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
module pli_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // pli_sync
